// *** design/tai_defines.svh ***
// Offsets, field positions, reset values and timing counts for the alarm block
// Assumes core_clk_i at 25 MHz; included by bare name
`ifndef TAI_DEFINES_SVH
`define TAI_DEFINES_SVH
`define TAI_ADDR_CONFIG 8'h40
`define TAI_ADDR_STATUS1 8'h41
`define TAI_ADDR_STATUS2 8'h42
`define TAI_ADDR_MASK1 8'h43
`define TAI_ADDR_MASK2 8'h44
`define TAI_ADDR_INTRUSION_CLEAR 8'h45
`define TAI_ADDR_EXT_MODE1 8'h4c
`define TAI_CFG_START 0
`define TAI_CFG_INT_EN 1
`define TAI_CFG_INT_CLEAR 3
`define TAI_CFG_RESET_OUT 4
`define TAI_CFG_RESET 8'h08
`define TAI_ST1_HIGH 0
`define TAI_ST1_LOW 1
`define TAI_ST2_INTRUSION 4
`define TAI_MASK2_RESET_EN 7
`define TAI_ICLR_GO 7
`define TAI_EXT_EXTENDED 0
`define TAI_EXT_MODE_LSB 1
`define TAI_EXT_CRIT 7
`define TAI_EXT_RESET 8'h00
`define TAI_MODE_ONE_TIME 2'h1
`define TAI_PULSE_MS 20
`define TAI_CLK_KHZ 25000
`define TAI_PULSE_CYCLES (`TAI_PULSE_MS * `TAI_CLK_KHZ)
`endif

// *** design/tai_pkg.sv ***
// Types shared by the alarm block
// Assumes tai_defines.svh is compiled alongside
package tai_pkg;
  typedef enum logic [1:0] {
    TAI_REPETITIVE = 2'h0,
    TAI_ONE_TIME = 2'h1,
    TAI_COMPARATOR = 2'h2
  } tai_mode_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tai_reg_req_type;
  typedef enum logic [2:0] {
    TAI_IDLE = 3'b001,
    TAI_PULSE = 3'b010,
    TAI_HOLD = 3'b100
  } tai_pulse_state_type;
endpackage

// *** design/tai_alarm.sv ***
// Temperature alarm, interrupt, intrusion clear, reset pin and tree test logic
// Assumes a serial-bus engine presents register accesses as one-cycle strobes,
// and the converter presents each finished conversion with a one-cycle done pulse.
`include "tai_defines.svh"

// Operation
// - Normal modes: alert idle, high raises interrupt
// - Normal repetitive: reassert above upper release point
// - Normal one-time: rearm only at release point
// - Default mode is normal one-time
// - Normal comparator follows upper limit only
// - Extended latches cleared by status/mode reads
// - Ext repetitive low until above low+hyst
// - Ext repetitive high until below high-hyst
// - Ext repetitive critical until below crit-hyst
// - Ext one-time low rearms above low+hyst
// - Ext one-time high rearms below high-hyst
// - Ext one-time critical rearms below crit-hyst
// - Ext comparator low released above low+hyst
// - Ext comparator high and critical with hysteresis
// - Status flags, masks, global enable gate line
// - Intrusion pin is active-high interrupt source
// - Intrusion clear drives pin low 20 ms
// - Status read returns then clears, line drops
// - Interrupt-clear bit drops line, halts loop
// - Reset bit drives reset pin 20 ms
// - External reset low restores register defaults
// - Tree test entered only before first config write
// - Tree result toggles on any included pin
// - 8-bit setpoints against 9-bit half-degree data
// - Hysteresis is 3-bit, one degree per step
module tai_alarm (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire tai_pkg::tai_reg_req_type req_i,
  output logic [7:0] rdata_o,
  input wire logic conv_done_i,
  input wire logic [8:0] temp_i,
  input wire logic [7:0] upper_limit_i,
  input wire logic [7:0] upper_release_point_i,
  input wire logic [7:0] lower_limit_i,
  input wire logic [7:0] overheat_limit_i,
  input wire logic [2:0] hysteresis_offset_i,
  output logic loop_run_o,
  output logic int_n_o,
  output logic overheat_alert_n_o,
  input wire logic chassis_intrusion_i,
  output logic chassis_intrusion_o,
  output logic chassis_intrusion_oe_n_o,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  input wire logic analog_out_test_entry_i,
  input wire logic [15:0] tree_pins_i,
  output logic tree_mode_o,
  output logic tree_test_result_o
);
  logic [2:0] ci_sync, rst_sync, te_sync;
  logic ci_lvl, ext_rst_lvl, te_lvl, soft_rst;
  logic [5:0] own_drive_hist;
  logic [7:0] cfg, st1, st2, mask1, mask2, ext1, iclr;
  logic cfg_written, tree_mode;
  logic high_armed, low_armed, crit_armed;
  logic ci_pulse_done, rst_pulse_done;
  logic signed [10:0] t2, up2, rel2, lo2, cr2, hy2;
  logic hi_ev, lo_ev, cr_ev, hi_rel, lo_rel, cr_rel, upper_rel_ev;
  logic hi_set, lo_set, cr_set;
  logic extended;
  tai_pkg::tai_mode_type mode;
  logic rd_st1, rd_st2, rd_ext1, wr_cfg;

  // Three-stage pin synchronisers; change taken when stages two and three agree
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ci_sync <= 3'h0;
      rst_sync <= 3'h7;
      te_sync <= 3'h0;
      ci_lvl <= 1'b0;
      ext_rst_lvl <= 1'b1;
      te_lvl <= 1'b0;
      own_drive_hist <= 6'h00;
    end else begin
      ci_sync <= {ci_sync[1:0], chassis_intrusion_i};
      rst_sync <= {rst_sync[1:0], reset_pin_i};
      te_sync <= {te_sync[1:0], analog_out_test_entry_i};
      own_drive_hist <= {own_drive_hist[4:0], !reset_pin_oe_n_o};
      if (ci_sync[1] == ci_sync[2]) ci_lvl <= ci_sync[2];
      if (rst_sync[1] == rst_sync[2]) ext_rst_lvl <= rst_sync[2];
      if (te_sync[1] == te_sync[2]) te_lvl <= te_sync[2];
    end
  end

  // Own pulse reads back low, also for a few cycles after release through the synchroniser
  assign soft_rst = !ext_rst_lvl && reset_pin_oe_n_o && !(|own_drive_hist);
  assign rd_st1 = req_i.rd && req_i.addr == `TAI_ADDR_STATUS1;
  assign rd_st2 = req_i.rd && req_i.addr == `TAI_ADDR_STATUS2;
  assign rd_ext1 = req_i.rd && req_i.addr == `TAI_ADDR_EXT_MODE1;
  assign wr_cfg = req_i.wr && req_i.addr == `TAI_ADDR_CONFIG;
  assign extended = ext1[`TAI_EXT_EXTENDED];
  assign mode = tai_pkg::tai_mode_type'(ext1[`TAI_EXT_MODE_LSB +: 2]);

  // Setpoints in half-degree units so they line up with the 9-bit data
  assign t2 = 11'(signed'(temp_i));
  assign up2 = 11'(signed'(upper_limit_i)) <<< 1;
  assign rel2 = 11'(signed'(upper_release_point_i)) <<< 1;
  assign lo2 = 11'(signed'(lower_limit_i)) <<< 1;
  assign cr2 = 11'(signed'(overheat_limit_i)) <<< 1;
  assign hy2 = 11'({hysteresis_offset_i, 1'b0});
  assign hi_ev = t2 > up2;
  assign lo_ev = t2 <= lo2;
  assign cr_ev = t2 > cr2;
  assign upper_rel_ev = t2 <= rel2;
  assign hi_rel = extended ? (t2 <= up2 - hy2) : (mode == tai_pkg::TAI_COMPARATOR ? !hi_ev : upper_rel_ev);
  assign lo_rel = t2 > lo2 + hy2;
  assign cr_rel = t2 <= cr2 - hy2;

  // Per-conversion set decisions
  always_comb begin
    hi_set = 1'b0;
    lo_set = 1'b0;
    cr_set = 1'b0;
    case (mode)
      tai_pkg::TAI_REPETITIVE: begin
        hi_set = hi_ev || (high_armed && !hi_rel);
        lo_set = extended && (lo_ev || (low_armed && !lo_rel));
        cr_set = extended && (cr_ev || (crit_armed && !cr_rel));
      end
      tai_pkg::TAI_ONE_TIME: begin
        hi_set = hi_ev && !high_armed;
        lo_set = extended && lo_ev && !low_armed;
        cr_set = extended && cr_ev && !crit_armed;
      end
      tai_pkg::TAI_COMPARATOR: begin
        hi_set = hi_ev || (high_armed && !hi_rel);
        lo_set = extended && (lo_ev || (low_armed && !lo_rel));
        cr_set = extended && (cr_ev || (crit_armed && !cr_rel));
      end
      default: hi_set = 1'b0;
    endcase
  end

  // Hysteresis memory: set by an event, cleared by the release point
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      high_armed <= 1'b0;
      low_armed <= 1'b0;
      crit_armed <= 1'b0;
    end else if (soft_rst) begin
      high_armed <= 1'b0;
      low_armed <= 1'b0;
      crit_armed <= 1'b0;
    end else if (conv_done_i && loop_run_o) begin
      high_armed <= hi_ev || (high_armed && !hi_rel);
      low_armed <= extended && (lo_ev || (low_armed && !lo_rel));
      crit_armed <= extended && (cr_ev || (crit_armed && !cr_rel));
    end
  end

  // Comparator flags track each conversion; set still beats a same-cycle read clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st1 <= 8'h00;
    end else if (soft_rst) begin
      st1 <= 8'h00;
    end else begin
      if (conv_done_i && loop_run_o) begin
        st1[`TAI_ST1_HIGH] <= hi_set || (st1[`TAI_ST1_HIGH] && !rd_st1 && mode != tai_pkg::TAI_COMPARATOR);
        st1[`TAI_ST1_LOW] <= lo_set || (st1[`TAI_ST1_LOW] && !rd_st1 && mode != tai_pkg::TAI_COMPARATOR);
      end else if (rd_st1) begin
        st1 <= 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st2 <= 8'h00;
    end else if (soft_rst) begin
      st2 <= 8'h00;
    end else begin
      st2[`TAI_ST2_INTRUSION] <= (ci_lvl && loop_run_o) || (st2[`TAI_ST2_INTRUSION] && !rd_st2);
    end
  end

  // Extended mode register; critical flag in bit 7 clears on its own read
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext1 <= `TAI_EXT_RESET;
      ext1[`TAI_EXT_MODE_LSB +: 2] <= `TAI_MODE_ONE_TIME;
    end else if (soft_rst) begin
      ext1 <= `TAI_EXT_RESET;
      ext1[`TAI_EXT_MODE_LSB +: 2] <= `TAI_MODE_ONE_TIME;
    end else begin
      if (req_i.wr && req_i.addr == `TAI_ADDR_EXT_MODE1) ext1[6:0] <= req_i.wdata[6:0];
      if (conv_done_i && loop_run_o)
        ext1[`TAI_EXT_CRIT] <= cr_set || (ext1[`TAI_EXT_CRIT] && !rd_ext1 && mode != tai_pkg::TAI_COMPARATOR);
      else if (rd_ext1) ext1[`TAI_EXT_CRIT] <= 1'b0;
    end
  end

  // Config, masks and intrusion clear; self-clearing bits drop when their pulse ends
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= `TAI_CFG_RESET;
      mask1 <= 8'h00;
      mask2 <= 8'h00;
      iclr <= 8'h00;
    end else if (soft_rst) begin
      cfg <= `TAI_CFG_RESET;
      mask1 <= 8'h00;
      mask2 <= 8'h00;
      iclr <= 8'h00;
    end else begin
      if (wr_cfg) cfg <= req_i.wdata;
      else if (rst_pulse_done) cfg[`TAI_CFG_RESET_OUT] <= 1'b0;
      if (!mask2[`TAI_MASK2_RESET_EN] && !wr_cfg) cfg[`TAI_CFG_RESET_OUT] <= 1'b0;
      if (req_i.wr && req_i.addr == `TAI_ADDR_MASK1) mask1 <= req_i.wdata;
      if (req_i.wr && req_i.addr == `TAI_ADDR_MASK2) mask2 <= req_i.wdata;
      if (req_i.wr && req_i.addr == `TAI_ADDR_INTRUSION_CLEAR) iclr <= req_i.wdata;
      else if (ci_pulse_done) iclr[`TAI_ICLR_GO] <= 1'b0;
    end
  end

  // Tree test: entry sampled only until the first configuration write
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_written <= 1'b0;
      tree_mode <= 1'b0;
    end else begin
      if (wr_cfg) cfg_written <= 1'b1;
      if (te_lvl && !cfg_written && !wr_cfg) tree_mode <= 1'b1;
    end
  end

  // Parity of the included pins gives an odd-count toggle for any single low
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) tree_test_result_o <= 1'b0;
    else tree_test_result_o <= ~^tree_pins_i;
  end

  // 20 ms low pulses; bits held high restart nothing until they self-clear
  tai_pulse u_ci_pulse (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .go_i(iclr[`TAI_ICLR_GO]),
    .active_o(chassis_intrusion_oe_n_o),
    .done_o(ci_pulse_done)
  );
  tai_pulse u_rst_pulse (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .go_i(cfg[`TAI_CFG_RESET_OUT] && mask2[`TAI_MASK2_RESET_EN]),
    .active_o(reset_pin_oe_n_o),
    .done_o(rst_pulse_done)
  );
  assign chassis_intrusion_o = 1'b0;
  assign reset_pin_o = 1'b0;

  assign loop_run_o = cfg[`TAI_CFG_START] && !cfg[`TAI_CFG_INT_CLEAR] && !tree_mode;
  assign int_n_o = !(cfg[`TAI_CFG_INT_EN] && !cfg[`TAI_CFG_INT_CLEAR] && !tree_mode &&
                     (|(st1 & ~mask1) || |(st2 & ~mask2 & 8'h7f)));
  assign overheat_alert_n_o = !(extended && ext1[`TAI_EXT_CRIT]);
  assign tree_mode_o = tree_mode;

  // Read data registered one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) rdata_o <= 8'h00;
    else if (req_i.rd) begin
      case (req_i.addr)
        `TAI_ADDR_CONFIG: rdata_o <= cfg;
        `TAI_ADDR_STATUS1: rdata_o <= st1;
        `TAI_ADDR_STATUS2: rdata_o <= st2;
        `TAI_ADDR_MASK1: rdata_o <= mask1;
        `TAI_ADDR_MASK2: rdata_o <= mask2;
        `TAI_ADDR_INTRUSION_CLEAR: rdata_o <= iclr;
        `TAI_ADDR_EXT_MODE1: rdata_o <= ext1;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  a_normal_no_alert: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !extended |-> overheat_alert_n_o) else $error("alert active in normal mode");
  a_read_clears_st1: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    rd_st1 && !conv_done_i && !soft_rst |=> st1 == 8'h00) else $error("status 1 not cleared");
  a_intclr_line_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cfg[`TAI_CFG_INT_CLEAR] |-> int_n_o && !loop_run_o) else $error("clear bit ignored");
  a_no_eval_between: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !conv_done_i && !rd_st1 && !soft_rst |=> $stable(st1)) else $error("status moved between conversions");
  a_tree_no_reentry: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cfg_written && !tree_mode |=> !tree_mode) else $error("tree mode re-entered");
  a_onetime_no_repeat: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    conv_done_i && loop_run_o && !soft_rst && mode == tai_pkg::TAI_ONE_TIME && high_armed && !st1[`TAI_ST1_HIGH]
    |=> !st1[`TAI_ST1_HIGH])
    else $error("one-time repeated");
  a_comp_follows: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    conv_done_i && loop_run_o && !soft_rst && !extended && mode == tai_pkg::TAI_COMPARATOR
    |=> st1[`TAI_ST1_HIGH] == $past(hi_ev)) else $error("comparator mismatch");
  a_ci_pulse_low: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $fell(chassis_intrusion_oe_n_o) |=> !chassis_intrusion_oe_n_o [*8]) else $error("short intrusion pulse");
  a_rst_pulse_en: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $fell(reset_pin_oe_n_o) |-> $past(mask2[`TAI_MASK2_RESET_EN])) else $error("reset pulse not enabled");
endmodule

module tai_pulse (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  output logic active_o,
  output logic done_o
);
  localparam logic [19:0] PULSE_CYCLES = 20'(`TAI_PULSE_CYCLES);
  tai_pkg::tai_pulse_state_type state;
  logic [19:0] count;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= tai_pkg::TAI_IDLE;
      count <= 20'h00000;
    end else begin
      case (state)
        tai_pkg::TAI_IDLE: if (go_i) begin
          state <= tai_pkg::TAI_PULSE;
          count <= 20'h00000;
        end
        tai_pkg::TAI_PULSE: begin
          count <= count + 20'h00001;
          if (count == PULSE_CYCLES - 20'h00001) state <= tai_pkg::TAI_HOLD;
        end
        tai_pkg::TAI_HOLD: if (!go_i) state <= tai_pkg::TAI_IDLE;
        default: state <= tai_pkg::TAI_IDLE;
      endcase
    end
  end
  // Low while driving: enable is active low
  assign active_o = state != tai_pkg::TAI_PULSE;
  assign done_o = state == tai_pkg::TAI_HOLD;
endmodule

// *** test/tai_far_end.sv ***
// Far-side model: external intrusion latch and the pulled-up reset line
// Assumes the bench gives it the device's open-drain enables and its own trip commands
module tai_far_end (
  input wire logic core_clk_i,
  input wire logic trip_i,
  input wire logic hold_reset_i,
  input wire logic chassis_intrusion_oe_n_i,
  input wire logic reset_pin_oe_n_i,
  output logic chassis_intrusion_o,
  output logic reset_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic latched = 1'b0;
  // Latch is cleared only by the device pulling the line low
  always @(posedge core_clk_i) begin
    if (!chassis_intrusion_oe_n_i) begin
      latched <= 1'b0;
    end else if (trip_i) begin
      latched <= 1'b1;
    end
  end
  assign chassis_intrusion_o = chassis_intrusion_oe_n_i & latched;
  // Pull-up wins unless someone sinks the line
  assign reset_pin_o = reset_pin_oe_n_i & !hold_reset_i;
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the alarm block: conversion table, then registers and pins
// Assumes limits upper 50, release 45, lower 10, critical 60, hysteresis 2 degrees
`define CHECK_EQ(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0] ext;
    logic [7:0] ra;
    logic [7:0] re;
    logic [8:0] t;
    logic [1:0] pins;
  } tai_row_type;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  tai_pkg::tai_reg_req_type req_i = '0;
  logic conv_done_i = 1'b0;
  logic [8:0] temp_i = 9'h000;
  logic [7:0] upper_limit_i = 8'h32;
  logic [7:0] upper_release_point_i = 8'h2d;
  logic [7:0] lower_limit_i = 8'h0a;
  logic [7:0] overheat_limit_i = 8'h3c;
  logic [2:0] hysteresis_offset_i = 3'h2;
  logic analog_out_test_entry_i = 1'b0;
  logic [15:0] tree_pins_i = 16'hffff;
  logic trip = 1'b0;
  logic hold_reset = 1'b0;
  logic [7:0] rdata_o;
  logic loop_run_o, int_n_o, overheat_alert_n_o, tree_mode_o, tree_test_result_o;
  logic chassis_intrusion_oe_n_o, reset_pin_oe_n_o, chassis_line, reset_line;
  int failures = 0;
  int samples_checked = 0;
  // Mode ff keeps the power-up mode; pins are {int_n, alert_n}
  tai_row_type rows [34] = '{
    '{8'hff, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'hff, 8'h41, 8'h01, 9'h066, 2'h3},
    '{8'hff, 8'h00, 8'h00, 9'h05e, 2'h3},
    '{8'hff, 8'h00, 8'h00, 9'h05a, 2'h3},
    '{8'hff, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'h00, 8'h00, 8'h00, 9'h05e, 2'h3},
    '{8'h00, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'h00, 8'h41, 8'h01, 9'h05e, 2'h1},
    '{8'h00, 8'h41, 8'h01, 9'h05a, 2'h3},
    '{8'h04, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'h04, 8'h00, 8'h00, 9'h05e, 2'h3},
    '{8'h04, 8'h00, 8'h00, 9'h014, 2'h3},
    '{8'h01, 8'h00, 8'h00, 9'h07a, 2'h0},
    '{8'h01, 8'h41, 8'h01, 9'h062, 2'h0},
    '{8'h01, 8'h4c, 8'h81, 9'h062, 2'h1},
    '{8'h01, 8'h41, 8'h01, 9'h060, 2'h3},
    '{8'h01, 8'h00, 8'h00, 9'h014, 2'h1},
    '{8'h01, 8'h41, 8'h02, 9'h018, 2'h1},
    '{8'h01, 8'h41, 8'h02, 9'h01a, 2'h3},
    '{8'h03, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'h03, 8'h41, 8'h01, 9'h066, 2'h3},
    '{8'h03, 8'h00, 8'h00, 9'h060, 2'h3},
    '{8'h03, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'h03, 8'h41, 8'h01, 9'h014, 2'h1},
    '{8'h03, 8'h41, 8'h02, 9'h018, 2'h3},
    '{8'h03, 8'h00, 8'h00, 9'h07a, 2'h0},
    '{8'h03, 8'h4c, 8'h83, 9'h07a, 2'h1},
    '{8'h05, 8'h00, 8'h00, 9'h014, 2'h1},
    '{8'h05, 8'h00, 8'h00, 9'h018, 2'h1},
    '{8'h05, 8'h00, 8'h00, 9'h01a, 2'h3},
    '{8'h05, 8'h00, 8'h00, 9'h066, 2'h1},
    '{8'h05, 8'h00, 8'h00, 9'h060, 2'h3},
    '{8'h05, 8'h00, 8'h00, 9'h07a, 2'h0},
    '{8'h05, 8'h00, 8'h00, 9'h074, 2'h1}
  };

  tai_alarm dut_u (
    .core_clk_i, .nrst_i, .req_i, .rdata_o, .conv_done_i, .temp_i,
    .upper_limit_i, .upper_release_point_i, .lower_limit_i, .overheat_limit_i, .hysteresis_offset_i,
    .loop_run_o, .int_n_o, .overheat_alert_n_o,
    .chassis_intrusion_i(chassis_line), .chassis_intrusion_o(), .chassis_intrusion_oe_n_o,
    .reset_pin_i(reset_line), .reset_pin_o(), .reset_pin_oe_n_o,
    .analog_out_test_entry_i, .tree_pins_i, .tree_mode_o, .tree_test_result_o
  );
  tai_far_end far_u (
    .core_clk_i, .trip_i(trip), .hold_reset_i(hold_reset),
    .chassis_intrusion_oe_n_i(chassis_intrusion_oe_n_o), .reset_pin_oe_n_i(reset_pin_oe_n_o),
    .chassis_intrusion_o(chassis_line), .reset_pin_o(reset_line)
  );

  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cycles(1);
    req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cycles(1);
    req_i = '0;
  endtask

  // Status reads far closer than the host minimum; the design must not rely on spacing.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cycles(1);
    req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cycles(1);
    req_i = '0;
    `CHECK_EQ(rdata_o, e)
  endtask

  task automatic conv(input logic [8:0] t);
    cycles(1);
    temp_i = t;
    conv_done_i = 1'b1;
    cycles(1);
    conv_done_i = 1'b0;
    cycles(1);
  endtask

  // Fresh reset per mode group, since latched state would leak across groups
  task automatic setup(input logic [7:0] ext);
    cycles(1);
    nrst_i = 1'b0;
    cycles(2);
    nrst_i = 1'b1;
    wr(8'h40, 8'h03);
    if (ext !== 8'hff) wr(8'h4c, ext);
  endtask

  initial begin
    cycles(12);
    nrst_i = 1'b1;
    foreach (rows[i]) begin
      if (i == 0 || rows[i].ext !== rows[i - 1].ext) setup(rows[i].ext);
      if (rows[i].ra !== 8'h00) rd(rows[i].ra, rows[i].re);
      conv(rows[i].t);
      `CHECK_EQ(int_n_o, rows[i].pins[1])
      `CHECK_EQ(overheat_alert_n_o, rows[i].pins[0])
    end
    setup(8'hff);
    wr(8'h40, 8'h08);
    `CHECK_EQ(loop_run_o, 1'b0)
    conv(9'h066);
    `CHECK_EQ(int_n_o, 1'b1)
    rd(8'h41, 8'h00);
    rd(8'h50, 8'h00);
    wr(8'h40, 8'h03);
    wr(8'h43, 8'h01);
    conv(9'h066);
    `CHECK_EQ(int_n_o, 1'b1)
    rd(8'h41, 8'h01);
    rd(8'h41, 8'h00);
    wr(8'h43, 8'h00);
    wr(8'h40, 8'h01);
    conv(9'h05a);
    conv(9'h066);
    `CHECK_EQ(int_n_o, 1'b1)
    wr(8'h40, 8'h03);
    `CHECK_EQ(int_n_o, 1'b0)
    wr(8'h40, 8'h0b);
    `CHECK_EQ(int_n_o, 1'b1)
    wr(8'h40, 8'h03);
    rd(8'h41, 8'h01);
    `CHECK_EQ(int_n_o, 1'b1)
    trip = 1'b1;
    cycles(1);
    trip = 1'b0;
    cycles(6);
    `CHECK_EQ(int_n_o, 1'b0)
    rd(8'h42, 8'h10);
    wr(8'h45, 8'h80);
    cycles(3);
    `CHECK_EQ(chassis_intrusion_oe_n_o, 1'b0)
    rd(8'h45, 8'h80);
    cycles(1000);
    `CHECK_EQ(chassis_line, 1'b0)
    setup(8'hff);
    wr(8'h40, 8'h13);
    cycles(3);
    `CHECK_EQ(reset_pin_oe_n_o, 1'b1)
    rd(8'h40, 8'h03);
    wr(8'h44, 8'h80);
    wr(8'h40, 8'h13);
    cycles(3);
    `CHECK_EQ(reset_pin_oe_n_o, 1'b0)
    setup(8'hff);
    wr(8'h43, 8'hff);
    hold_reset = 1'b1;
    cycles(5);
    hold_reset = 1'b0;
    cycles(5);
    rd(8'h43, 8'h00);
    rd(8'h40, 8'h08);
    nrst_i = 1'b0;
    analog_out_test_entry_i = 1'b1;
    cycles(2);
    nrst_i = 1'b1;
    cycles(6);
    `CHECK_EQ(tree_mode_o, 1'b1)
    `CHECK_EQ(tree_test_result_o, 1'b1)
    tree_pins_i = 16'hffbf;
    cycles(3);
    `CHECK_EQ(tree_test_result_o, 1'b0)
    tree_pins_i = 16'hff3f;
    cycles(3);
    `CHECK_EQ(tree_test_result_o, 1'b1)
    analog_out_test_entry_i = 1'b0;
    setup(8'hff);
    analog_out_test_entry_i = 1'b1;
    cycles(6);
    `CHECK_EQ(tree_mode_o, 1'b0)
    end_of_test();
  end

  // Whole run needs about 1300 cycles; this margin catches a hang
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    end_of_test();
  end
endmodule
